// ---- hw/bfsr_pkg.sv ----
package bfsr_pkg;

    // Widths of the readout path
    localparam int unsigned BFSR_CNT_W  = 4;
    localparam int unsigned BFSR_STAT_W = 16;
    localparam int unsigned BFSR_SYNC_W = 12;

    // Bit positions in the fault status word
    localparam int unsigned BFSR_BIT_FAULT     = 0;
    localparam int unsigned BFSR_BIT_CHECK     = 1;
    localparam int unsigned BFSR_BIT_LIVE_LO   = 2;
    localparam int unsigned BFSR_BIT_LIVE_HI   = 5;
    localparam int unsigned BFSR_BIT_STROBE_LO = 6;
    localparam int unsigned BFSR_BIT_STROBE_HI = 9;
    localparam int unsigned BFSR_BIT_GATE_EDGE = 10;
    localparam int unsigned BFSR_BIT_GATE_ON   = 11;
    localparam int unsigned BFSR_BIT_BELOW_REF = 12;
    localparam int unsigned BFSR_BIT_HS_OC     = 13;
    localparam int unsigned BFSR_BIT_UV        = 14;
    localparam int unsigned BFSR_BIT_OT        = 15;
    localparam int unsigned BFSR_FLAG_LO       = 11;
    localparam int unsigned BFSR_FLAG_N        = 5;

    // Reset values, and the fixed value of the check bit
    localparam logic [BFSR_CNT_W-1:0]  BFSR_CNT_RST  = 4'h0;
    localparam logic [BFSR_STAT_W-1:0] BFSR_STAT_RST = 16'h0000;
    localparam logic [BFSR_SYNC_W-1:0] BFSR_SYNC_RST = 12'h000;
    localparam logic                   BFSR_CHECK_VAL = 1'b1;

    // One bit per bridge switch; last member is bit 0
    typedef struct packed {
        logic high_side_switch_b;
        logic high_side_switch_a;
        logic low_side_switch_b;
        logic low_side_switch_a;
    } bfsr_switch_s;

    // Raw analog comparator and monitor results
    typedef struct packed {
        logic         over_temp;
        logic         under_volt;
        logic         hs_overcurrent;
        logic         below_ref;
        logic         gate_high;
        bfsr_switch_s bridge;
    } bfsr_sense_s;

endpackage

// ---- hw/bfsr_readout.sv ----
`timescale 1ns/1ns
module bfsr_readout
    import bfsr_pkg::*;
(
    input  wire logic                  phase_clk,
    input  wire logic                  rst_n,
    input  wire logic                  cnt_clr,
    input  wire logic                  clk_en,
    output logic      [BFSR_CNT_W-1:0] cnt_gray_q
);

    // Counter held at zero while the bridge is active
    logic                  arst_n;
    logic [BFSR_CNT_W-1:0] cnt_q;
    logic [BFSR_CNT_W-1:0] cnt_d;
    logic [BFSR_CNT_W-1:0] cnt_gray_d;
    logic                  en_s1_q;
    logic                  en_s2_q;

    // Clear comes from a flop, so the gated reset stays glitch free
    assign arst_n = rst_n & ~cnt_clr;

    // Next count: one step per phase rising edge, wraps 15 to 0
    always_comb begin
        cnt_d = cnt_q;
        if (en_s2_q) begin
            cnt_d = cnt_q + 4'h1;
        end
        cnt_gray_d = cnt_d ^ (cnt_d >> 1);
    end

    // Link side registers, gray code for the crossing
    always_ff @(posedge phase_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q      <= BFSR_CNT_RST;
            cnt_gray_q <= BFSR_CNT_RST;
            // Enable copies start set, so the first phase edge after a clear counts
            en_s1_q    <= 1'b1;
            en_s2_q    <= 1'b1;
        end else begin
            en_s1_q    <= clk_en;
            en_s2_q    <= en_s1_q;
            cnt_q      <= cnt_d;
            cnt_gray_q <= cnt_gray_d;
        end
    end

endmodule // bfsr_readout

// ---- hw/bfsr_top.sv ----
`timescale 1ns/1ns
module bfsr_top
    import bfsr_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire logic         drive_activate,
    input  wire logic         direction_input,
    input  wire logic         retrigger_input,
    input  wire bfsr_sense_s  sense,
    output bfsr_switch_s      switch_q,
    output logic              bridge_hiz_q,
    output logic              fault_serial_out,
    output logic              fault_serial_oe_n_q
);

    // Input synchronisers
    logic [BFSR_SYNC_W-1:0] pin_s1_q;
    logic [BFSR_SYNC_W-1:0] pin_s2_q;
    logic [BFSR_SYNC_W-1:0] pin_raw;

    // Edge detection history
    logic act_prev_q;
    logic act_prev_d;
    logic ret_prev_q;
    logic ret_prev_d;

    // Synchronised pin views
    bfsr_sense_s sense_s;
    logic        act;
    logic        phase;
    logic        retrig;
    logic        act_fall;
    logic        act_rise;
    logic        ret_fall;

    // Readout counter crossing
    logic [BFSR_CNT_W-1:0] gray_link;
    logic [BFSR_CNT_W-1:0] gray_s1_q;
    logic [BFSR_CNT_W-1:0] gray_s2_q;
    logic [BFSR_CNT_W-1:0] sel_idx;
    logic                  cnt_clr_q;
    logic                  cnt_clr_d;
    logic                  clk_en_q;

    // Stored diagnostics
    logic [BFSR_STAT_W-1:0] stat_q;
    logic [BFSR_STAT_W-1:0] stat_d;
    logic [BFSR_STAT_W-1:0] word;
    logic [BFSR_FLAG_N-1:0] flag_evt;

    // Bridge control state
    logic         chop_q;
    logic         chop_d;
    logic         stage_block;
    bfsr_switch_s switch_d;
    logic         bridge_hiz_d;

    // Serial line
    logic sel_bit;
    logic line_level;
    logic fault_serial_oe_n_d;

    // Pack every pin for one shared two-stage synchroniser
    assign pin_raw = {retrigger_input, direction_input, drive_activate, sense};

    // Reset values are zero, so a floating pin reads as low until driven
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_q <= BFSR_SYNC_RST;
            pin_s2_q <= BFSR_SYNC_RST;
        end else if (clk_en) begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Unpack the second stage only
    assign sense_s = pin_s2_q[8:0];
    assign act     = pin_s2_q[9];
    assign phase   = pin_s2_q[10];
    assign retrig  = pin_s2_q[11];

    // Edges of the synchronised activate and retrigger levels
    assign act_fall   = act_prev_q & ~act;
    assign act_rise   = ~act_prev_q & act;
    assign ret_fall   = ret_prev_q & ~retrig;
    assign act_prev_d = act;
    assign ret_prev_d = retrig;

    // Counter is cleared from a flop so the link sees a clean level
    assign cnt_clr_d = act;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            act_prev_q <= 1'b0;
            ret_prev_q <= 1'b0;
            cnt_clr_q  <= 1'b1;
            clk_en_q   <= 1'b0;
        end else begin
            clk_en_q <= clk_en;
            if (clk_en) begin
                act_prev_q <= act_prev_d;
                ret_prev_q <= ret_prev_d;
                cnt_clr_q  <= cnt_clr_d;
            end
        end
    end

    // Counter clocked by the phase pin itself
    bfsr_readout u_readout (
        .phase_clk  (direction_input),
        .rst_n      (rst_n),
        .cnt_clr    (cnt_clr_q),
        .clk_en     (clk_en_q),
        .cnt_gray_q (gray_link)
    );

    // Gray pointer into the system domain, one bit changes per step
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gray_s1_q <= BFSR_CNT_RST;
            gray_s2_q <= BFSR_CNT_RST;
        end else if (clk_en) begin
            gray_s1_q <= gray_link;
            gray_s2_q <= gray_s1_q;
        end
    end

    // Gray to binary, one xor chain per bit
    genvar gi;
    generate
        for (gi = 0; gi < BFSR_CNT_W; gi++) begin : g_gray
            assign sel_idx[gi] = ^gray_s2_q[BFSR_CNT_W-1:gi];
        end
    endgenerate

    // Flag events for bits 11 to 15, in bit order
    assign flag_evt = {sense_s.over_temp,
                       sense_s.under_volt,
                       sense_s.hs_overcurrent,
                       sense_s.below_ref,
                       sense_s.gate_high};

    // Stored bits: strobe copies and latched flags
    always_comb begin
        stat_d = stat_q;
        // Strobe on the activate falling edge
        if (act_fall) begin
            stat_d[BFSR_BIT_STROBE_HI:BFSR_BIT_STROBE_LO] = sense_s.bridge;
            stat_d[BFSR_BIT_GATE_EDGE] = sense_s.gate_high;
        end
        // Rising edge wipes memories; a same-cycle event still sets
        if (act_rise) begin
            stat_d[BFSR_BIT_GATE_EDGE:BFSR_BIT_STROBE_LO] = 5'h00;
            stat_d[BFSR_BIT_OT:BFSR_FLAG_LO] = 5'h00;
        end
        for (int i = 0; i < BFSR_FLAG_N; i++) begin
            if (act && flag_evt[i]) begin
                stat_d[BFSR_FLAG_LO+i] = 1'b1;
            end
        end
        // Unused slots stay zero in the stored copy
        stat_d[BFSR_BIT_LIVE_HI:BFSR_BIT_FAULT] = 6'h00;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= BFSR_STAT_RST;
        end else if (clk_en) begin
            stat_q <= stat_d;
        end
    end

    // Full readout word: live, check and summary bits join the store
    always_comb begin
        word = stat_q;
        word[BFSR_BIT_FAULT] = |stat_q[BFSR_BIT_OT:BFSR_BIT_HS_OC];
        word[BFSR_BIT_CHECK] = BFSR_CHECK_VAL;
        word[BFSR_BIT_LIVE_HI:BFSR_BIT_LIVE_LO] = sense_s.bridge;
    end

    // Sixteen-way selection by the crossed counter
    assign sel_bit = word[sel_idx];

    // Line level: summary while active, else selected bit per phase
    always_comb begin
        if (act) begin
            line_level = ~word[BFSR_BIT_FAULT];
        end else if (phase) begin
            line_level = ~sel_bit;
        end else begin
            line_level = sel_bit;
        end
        // Open drain: enable low pulls the line low
        fault_serial_oe_n_d = line_level;
    end

    // Drive flip-flop: reset wins so a high current never restarts
    always_comb begin
        chop_d = chop_q;
        if (!sense_s.below_ref) begin
            chop_d = 1'b0;
        end else if (ret_fall) begin
            chop_d = 1'b1;
        end
    end

    // Thermal, supply and overcurrent faults act live so the stage recovers when cleared
    assign stage_block = sense_s.over_temp | sense_s.under_volt | sense_s.hs_overcurrent;

    // Switch pattern per activate and phase
    always_comb begin
        switch_d     = '0;
        bridge_hiz_d = ~act;
        if (act && !stage_block) begin
            if (!phase) begin
                switch_d.high_side_switch_b = 1'b1;
                switch_d.low_side_switch_a  = chop_q;
            end else begin
                switch_d.high_side_switch_a = 1'b1;
                switch_d.low_side_switch_b  = chop_q;
            end
        end
    end

    // Output flops; line starts released
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chop_q              <= 1'b0;
            switch_q            <= '0;
            bridge_hiz_q        <= 1'b1;
            fault_serial_oe_n_q <= 1'b1;
        end else if (clk_en) begin
            chop_q              <= chop_d;
            switch_q            <= switch_d;
            bridge_hiz_q        <= bridge_hiz_d;
            fault_serial_oe_n_q <= fault_serial_oe_n_d;
        end
    end

    // Open-drain data is always low; only the enable moves
    assign fault_serial_out = 1'b0;

endmodule // bfsr_top

// ---- testbench/bfsr_top_checker.sv ----
`timescale 1ns/1ns
module bfsr_top_checker
    import bfsr_pkg::*;
(
    input wire logic         sys_clk,
    input wire logic         rst_n,
    input wire logic         drive_activate,
    input wire logic         direction_input,
    input wire bfsr_sense_s  sense,
    input wire bfsr_switch_s switch_q,
    input wire logic         bridge_hiz_q,
    input wire logic         fault_serial_out,
    input wire logic         fault_serial_oe_n_q
);
    // Live faults that must drop every stage
    wire logic flt = sense.over_temp | sense.under_volt | sense.hs_overcurrent;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // Steady states long enough to pass the input syncs
    sequence s_idle; (!drive_activate)[*4]; endsequence
    sequence s_fwd; (drive_activate && !direction_input && !flt)[*4]; endsequence
    sequence s_rev; (drive_activate && direction_input && !flt)[*4]; endsequence
    sequence s_rise; $rose(drive_activate) ##0 (drive_activate && !flt)[*8]; endsequence

    chk_idle_hiz: assert property (s_idle |-> bridge_hiz_q && switch_q == 4'h0)
        else $error("bridge driven while idle");
    chk_fwd_drive: assert property (s_fwd |-> !bridge_hiz_q &&
        switch_q.high_side_switch_b && !switch_q.high_side_switch_a && !switch_q.low_side_switch_b)
        else $error("wrong switches for phase low");
    chk_rev_drive: assert property (s_rev |-> !bridge_hiz_q &&
        switch_q.high_side_switch_a && !switch_q.high_side_switch_b && !switch_q.low_side_switch_a)
        else $error("wrong switches for phase high");
    chk_fault_off: assert property (flt[*4] |-> switch_q == 4'h0)
        else $error("stage on during fault");
    chk_chop_off: assert property ((!sense.below_ref)[*5] |->
        !switch_q.low_side_switch_a && !switch_q.low_side_switch_b)
        else $error("low side on above reference");
    chk_od_low: assert property (fault_serial_out == 1'b0)
        else $error("open drain data not low");
    chk_fault_line: assert property ((drive_activate && flt)[*8] |-> !fault_serial_oe_n_q)
        else $error("fault not shown on line");
    chk_clear_line: assert property (s_rise |-> fault_serial_oe_n_q)
        else $error("flags not cleared on activate");
endmodule // bfsr_top_checker

// ---- testbench/bfsr_mcu_model.sv ----
`timescale 1ns/1ns
module bfsr_mcu_model (
    output logic      drive_activate,
    output logic      direction_input,
    output logic      retrigger_input,
    input  wire logic line
);
    // Pins start low, as an open input reads
    initial begin
        drive_activate = 1'b0;
        direction_input = 1'b0;
        retrigger_input = 1'b0;
    end

    // Changes land off the system clock edge on purpose
    task automatic set_pins(input logic act, input logic dir);
        #3;
        drive_activate <= act;
        direction_input <= dir;
    endtask

    // Falling edge restarts the chopped low side
    task automatic retrig();
        #3 retrigger_input <= 1'b1;
        #100 retrigger_input <= 1'b0;
    endtask

    // Phase stands still outside the frame; extra rise leaves counter off zero
    task automatic read_word(output logic [15:0] plain, output logic [15:0] inv);
        int k;
        plain[0] = line;
        for (k = 1; k <= 17; k++) begin
            #3 direction_input <= 1'b1;
            #77 if (k <= 16) inv[k % 16] = line;
            direction_input <= 1'b0;
            #80 if (k < 16) plain[k] = line;
        end
    endtask
endmodule // bfsr_mcu_model

// ---- testbench/bfsr_top_bench.sv ----
`timescale 1ns/1ns
module bfsr_top_bench
    import bfsr_pkg::*;
;
    logic         sys_clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         clk_en = 1'b1;
    bfsr_sense_s  sense = '0;
    wire logic    drive_activate;
    wire logic    direction_input;
    wire logic    retrigger_input;
    bfsr_switch_s switch_q;
    logic         bridge_hiz_q;
    logic         fault_serial_out;
    logic         fault_serial_oe_n_q;
    logic [15:0]  plain;
    logic [15:0]  inv;
    int           err_total = 0;
    int           tests_run = 0;

    always #5 sys_clk = ~sys_clk;

    bfsr_top dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
        .drive_activate(drive_activate), .direction_input(direction_input),
        .retrigger_input(retrigger_input), .sense(sense), .switch_q(switch_q),
        .bridge_hiz_q(bridge_hiz_q), .fault_serial_out(fault_serial_out),
        .fault_serial_oe_n_q(fault_serial_oe_n_q));

    // Line level follows the released or pulled drain
    bfsr_mcu_model u_mcu (
        .drive_activate(drive_activate), .direction_input(direction_input),
        .retrigger_input(retrigger_input), .line(fault_serial_oe_n_q));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic drv_chk(input logic [15:0] exp);
        check("bridge", {11'h0, bridge_hiz_q, switch_q}, exp);
    endtask

    // One active spell, then a full readout after the falling edge
    task automatic frame(input bfsr_sense_s act_s, input bfsr_sense_s fall_s,
                         input logic [3:0] live, input logic [15:0] exp);
        u_mcu.set_pins(1'b1, 1'b0);
        tick(10);
        sense <= act_s;
        tick(10);
        sense <= fall_s;
        tick(10);
        check("line_active", {15'h0, fault_serial_oe_n_q}, {15'h0, ~exp[0]});
        u_mcu.set_pins(1'b0, 1'b0);
        tick(12);
        sense <= bfsr_sense_s'({5'h00, live});
        tick(10);
        u_mcu.read_word(plain, inv);
        check("plain", plain, exp);
        check("inverted", inv, ~exp);
        $display("frame %h done", exp);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Bridge truth table, chopping, then three readout frames
    initial begin
        tick(10);
        rst_n <= 1'b1;
        tick(5);
        u_mcu.set_pins(1'b1, 1'b0);
        sense <= 9'h020;
        tick(10);
        u_mcu.retrig();
        tick(10);
        drv_chk(16'h0009);
        sense <= 9'h000;
        tick(6);
        drv_chk(16'h0008);
        u_mcu.set_pins(1'b1, 1'b1);
        sense <= 9'h020;
        tick(6);
        drv_chk(16'h0004);
        u_mcu.retrig();
        tick(10);
        drv_chk(16'h0006);
        sense <= 9'h080;
        tick(6);
        drv_chk(16'h0000);
        sense <= 9'h000;
        u_mcu.set_pins(1'b0, 1'b1);
        tick(6);
        drv_chk(16'h0010);
        $display("bridge test done");
        frame(9'h030, 9'h035, 4'hA, 16'h1D6A);
        frame(9'h1C0, 9'h000, 4'hF, 16'hE03F);
        frame(9'h000, 9'h000, 4'h0, 16'h0002);
        wrap_up();
    end

    // Whole run needs about 11 us; cut a hang well beyond that
    initial begin
        #100000;
        err_total++;
        wrap_up();
    end
endmodule // bfsr_top_bench

bind bfsr_top bfsr_top_checker u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .drive_activate(drive_activate),
    .direction_input(direction_input), .sense(sense), .switch_q(switch_q),
    .bridge_hiz_q(bridge_hiz_q), .fault_serial_out(fault_serial_out),
    .fault_serial_oe_n_q(fault_serial_oe_n_q));
